// *** rtl/msr_ctrl.sv ***
// Supervisory shutdown, reference search and command priority logic
//
// Function
// - Switch-closed flag reads zero while the switch input senses open.
// - Switch state triggers no automatic action; flag only mirrors input.
// - Enter shutdown when temperature rises above thermal shutdown threshold.
// - Enter shutdown when supply falls below undervoltage shutdown level.
// - Electrical fault sets electrical-defect flag and enters shutdown.
// - Charge pump failure sets pump-failure flag and enters shutdown.
// - Bridge outputs high impedance while in shutdown.
// - On entering shutdown copy actual position into target position.
// - Bus interface stays fully operational during shutdown.
// - Leave shutdown only when causes cleared and full status read follows.
// - On leaving shutdown apply hold current, clock, pump; accept commands.
// - First reference motion uses given velocities and RAM acceleration.
// - Second reference motion rectangular, never faster than minimum velocity.
// - After second motion clear position; go to secure unless -1024.
// - During reference search ignore all commands except immediate halt.
// - Deadlock left only by immediate halt then full status read.
// - Two temperature pre-warning thresholds raise warning indications.
// - Undervoltage warning level raises warning without shutdown.
// - Ignore load-target and go-safe commands while lost-step flag set.
// - In moving state immediate halt beats decelerated halt beats arrival.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
`include "msr_cfg.svh"
module msr_ctrl #(
  parameter int POS_W = 16,
  parameter int STEP_DIV = `MSR_STEP_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire msr_pkg::msr_sense_s sense_in,
  output msr_pkg::msr_drive_s drive_out,
  output logic step_q,
  output logic dir_q,
  output logic [7:0] step_rate_q
);
  // Bus decode
  wire bus_acc = psel && penable;
  wire bus_wr = bus_acc && pwrite;
  wire bus_rd = bus_acc && !pwrite;
  wire hit_cmd = paddr == `MSR_ADDR_CMD;
  wire hit_tgt = paddr == `MSR_ADDR_TARGET;
  wire hit_sec = paddr == `MSR_ADDR_SECURE;
  wire hit_i1 = paddr == `MSR_ADDR_INIT1;
  wire hit_i2 = paddr == `MSR_ADDR_INIT2;
  wire hit_vel = paddr == `MSR_ADDR_VEL;
  wire hit_sts = paddr == `MSR_ADDR_STATUS;
  wire hit_act = paddr == `MSR_ADDR_ACTUAL_POSITION;
  wire hit_tpo = paddr == `MSR_ADDR_TGTPOS;
  wire mapped = hit_cmd | hit_tgt | hit_sec | hit_i1 | hit_i2 | hit_vel | hit_sts
    | hit_act | hit_tpo;

  msr_pkg::msr_state_e state_q, state_d;
  logic [POS_W-1:0] act_q, act_d, tag_q, tag_d;
  logic [POS_W-1:0] cmd_tgt_q, init1_q, init2_q;
  logic [10:0] secure_q;
  logic [3:0] vmin_q, vmax_q, acc_q;
  logic [3:0] cmd_q;
  logic cmd_vld_q;
  logic lost_step_q, lost_step_d;
  logic eldef_q, pump_fail_q;
  logic [15:0] div_q;
  logic [7:0] rate_q, rate_d;

  // Host writes of position and velocity parameters are taken in every state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_tgt_q <= `MSR_RESET_POS;
      init1_q <= `MSR_RESET_POS;
      init2_q <= `MSR_RESET_POS;
      secure_q <= `MSR_SECURE_OFF;
      {vmin_q, vmax_q, acc_q} <= 12'h000;
    end else if (bus_wr) begin
      if (hit_tgt) cmd_tgt_q <= pwdata[POS_W-1:0];
      if (hit_sec) secure_q <= pwdata[10:0];
      if (hit_i1) init1_q <= pwdata[POS_W-1:0];
      if (hit_i2) init2_q <= pwdata[POS_W-1:0];
      if (hit_vel) {acc_q, vmax_q, vmin_q} <= pwdata[11:0];
    end
  end

  // One-cycle command strobe from a write to the command word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 4'h0;
      cmd_vld_q <= 1'b0;
    end else begin
      cmd_vld_q <= bus_wr && hit_cmd;
      cmd_q <= pwdata[3:0];
    end
  end

  wire c_full = cmd_vld_q && cmd_q == `MSR_CMD_FULL_STATUS;
  wire c_load = cmd_vld_q && cmd_q == `MSR_CMD_LOAD_TARGET && !lost_step_q;
  wire c_safe = cmd_vld_q && cmd_q == `MSR_CMD_GO_SAFE && !lost_step_q;
  wire c_ref = cmd_vld_q && cmd_q == `MSR_CMD_REF_SEARCH;
  wire c_imm = cmd_vld_q && cmd_q == `MSR_CMD_IMM_HALT;
  wire c_dec = cmd_vld_q && cmd_q == `MSR_CMD_DEC_HALT;

  // Fault causes, sampled every cycle
  wire fault_now = sense_in.thermal_shutdown | sense_in.undervoltage_shutdown
    | sense_in.electrical_defect | sense_in.pump_failure;
  // Sticky defect flags only report; the read that clears them may also end shutdown
  wire faults_clear = !fault_now;
  wire secure_en = secure_q != `MSR_SECURE_OFF;
  wire [POS_W-1:0] secure_pos = POS_W'({{(POS_W-11){secure_q[10]}}, secure_q})
    << `MSR_SECURE_SHIFT;
  wire at_tag = act_q == tag_q;
  wire moving = state_q == msr_pkg::ST_MOVING || state_q == msr_pkg::ST_REF1
    || state_q == msr_pkg::ST_REF2 || state_q == msr_pkg::ST_DEC_HALT;
  wire step_en = div_q == 16'h0000;

  // Defect flags stick until a full status read with the cause gone; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eldef_q <= 1'b0;
      pump_fail_q <= 1'b0;
    end else begin
      eldef_q <= sense_in.electrical_defect | (eldef_q & !c_full);
      pump_fail_q <= sense_in.pump_failure | (pump_fail_q & !c_full);
    end
  end

  // Step pacing enable; faster profile index shortens the interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= 16'h0000;
    else if (step_en) div_q <= 16'(STEP_DIV - 1) >> rate_q[3:0];
    else div_q <= div_q - 16'h0001;
  end

  always_comb begin
    state_d = state_q;
    act_d = act_q;
    tag_d = tag_q;
    lost_step_d = lost_step_q;
    rate_d = rate_q;
    if (moving && step_en && !at_tag) act_d = act_q + (tag_q[POS_W-1:0] > act_q ?
      POS_W'(1) : {POS_W{1'b1}});
    if (fault_now && state_q != msr_pkg::ST_SHUTDOWN) begin
      state_d = msr_pkg::ST_SHUTDOWN;
      tag_d = act_q;
      act_d = act_q;
    end else begin
      case (state_q)
        msr_pkg::ST_SHUTDOWN: begin
          if (c_full && faults_clear) begin
            state_d = msr_pkg::ST_STOPPED;
            lost_step_d = 1'b0;
          end
        end
        msr_pkg::ST_STOPPED: begin
          if (c_ref) begin
            state_d = msr_pkg::ST_REF1;
            tag_d = init1_q;
            rate_d = {vmin_q, vmax_q};
          end else if (c_load) begin
            tag_d = cmd_tgt_q;
            state_d = msr_pkg::ST_MOVING;
          end else if (c_safe && secure_en) begin
            tag_d = secure_pos;
            state_d = msr_pkg::ST_MOVING;
          end
          if (c_full) lost_step_d = 1'b0;
        end
        msr_pkg::ST_MOVING: begin
          if (c_imm) begin
            state_d = msr_pkg::ST_IMM_HALT;
            lost_step_d = 1'b1;
          end else if (c_dec) state_d = msr_pkg::ST_DEC_HALT;
          else if (c_load) tag_d = cmd_tgt_q;
          else if (c_safe && secure_en) tag_d = secure_pos;
          else if (at_tag) state_d = msr_pkg::ST_STOPPED;
        end
        msr_pkg::ST_REF1, msr_pkg::ST_REF2: begin
          if (c_imm) begin
            state_d = msr_pkg::ST_IMM_HALT;
            lost_step_d = 1'b1;
          end else if (at_tag && state_q == msr_pkg::ST_REF1) begin
            state_d = msr_pkg::ST_REF2;
            tag_d = init2_q;
            rate_d = {4'h0, vmin_q};
          end else if (at_tag) begin
            act_d = `MSR_RESET_POS;
            tag_d = secure_en ? secure_pos : `MSR_RESET_POS;
            state_d = secure_en ? msr_pkg::ST_MOVING : msr_pkg::ST_STOPPED;
          end
        end
        msr_pkg::ST_DEC_HALT: begin
          if (c_imm) begin
            state_d = msr_pkg::ST_IMM_HALT;
            lost_step_d = 1'b1;
          end else begin
            state_d = msr_pkg::ST_STOPPED;
            // Keep a step taken this cycle, so target and position agree
            tag_d = act_d;
          end
        end
        msr_pkg::ST_IMM_HALT: begin
          tag_d = act_q;
          if (c_full) state_d = msr_pkg::ST_STOPPED;
        end
        default: state_d = msr_pkg::ST_SHUTDOWN;
      endcase
    end
  end

  // Power-on starts in shutdown so the first full status read activates it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= msr_pkg::ST_SHUTDOWN;
      act_q <= `MSR_RESET_POS;
      tag_q <= `MSR_RESET_POS;
      lost_step_q <= 1'b0;
      rate_q <= 8'h00;
    end else begin
      state_q <= state_d;
      act_q <= act_d;
      tag_q <= tag_d;
      lost_step_q <= lost_step_d;
      rate_q <= rate_d;
    end
  end

  // Motor-side outputs, registered
  wire shut_d = state_d == msr_pkg::ST_SHUTDOWN;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_out <= 4'b1000;
      step_q <= 1'b0;
      dir_q <= 1'b0;
      step_rate_q <= 8'h00;
    end else begin
      drive_out.bridge_hiz <= shut_d;
      drive_out.hold_current <= !shut_d;
      drive_out.motor_clk_en <= !shut_d;
      drive_out.pump_en <= !shut_d;
      step_q <= act_d != act_q;
      dir_q <= tag_q > act_q;
      // Second motion carries only the minimum velocity, no ramp
      step_rate_q <= state_q == msr_pkg::ST_REF2 ? {4'h0, vmin_q} : {acc_q, vmax_q};
    end
  end

  // Status word; switch bit is a pure mirror with no side effects
  wire [31:0] status_w = {16'h0000, 1'b0, state_q,
    lost_step_q, pump_fail_q, eldef_q,
    sense_in.thermal_shutdown, sense_in.temp_warn_hi,
    sense_in.temp_warn_lo, sense_in.undervoltage_warning,
    sense_in.switch_closed};
  wire [31:0] rd_mux = hit_sts ? status_w
    : hit_act ? 32'(act_q)
    : hit_tpo ? 32'(tag_q)
    : hit_tgt ? 32'(cmd_tgt_q)
    : hit_sec ? {21'h00_0000, secure_q}
    : hit_i1 ? 32'(init1_q)
    : hit_i2 ? 32'(init2_q)
    : hit_vel ? {20'h0_0000, acc_q, vmax_q, vmin_q}
    : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : prdata;
    end
  end

  sequence s_fault;
    fault_now && state_q != msr_pkg::ST_SHUTDOWN;
  endsequence
  sequence s_status_rd;
    psel && !penable && !pwrite && hit_sts;
  endsequence

  // Shutdown entry
  a_fault_enters_shut: assert property (@(posedge pclk) disable iff (!presetn)
    s_fault |=> state_q == msr_pkg::ST_SHUTDOWN)
    else $error("no shutdown on fault");
  a_thermal_shut: assert property (@(posedge pclk) disable iff (!presetn)
    sense_in.thermal_shutdown |=> state_q == msr_pkg::ST_SHUTDOWN)
    else $error("no thermal shutdown");
  a_uv_shut: assert property (@(posedge pclk) disable iff (!presetn)
    sense_in.undervoltage_shutdown |=> state_q == msr_pkg::ST_SHUTDOWN)
    else $error("no supply shutdown");
  a_eldef_set: assert property (@(posedge pclk) disable iff (!presetn)
    sense_in.electrical_defect |=> eldef_q)
    else $error("defect flag not set");
  a_pump_set: assert property (@(posedge pclk) disable iff (!presetn)
    sense_in.pump_failure |=> pump_fail_q)
    else $error("pump flag not set");
  a_bridge_hiz_shut: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_SHUTDOWN |-> drive_out.bridge_hiz)
    else $error("bridge driven");
  a_shut_copies_pos: assert property (@(posedge pclk) disable iff (!presetn)
    s_fault |=> tag_q == $past(act_q))
    else $error("target not loaded");

  // Bus keeps working in every state
  a_write_in_shut: assert property (@(posedge pclk) disable iff (!presetn)
    bus_wr && hit_tgt |=> cmd_tgt_q == $past(pwdata[POS_W-1:0]))
    else $error("write lost");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("no ready");

  // Shutdown exit
  a_exit_needs_read: assert property (@(posedge pclk) disable iff (!presetn)
    $past(state_q) == msr_pkg::ST_SHUTDOWN && state_q != msr_pkg::ST_SHUTDOWN
    |-> $past(c_full)) else $error("exit without read");
  a_shut_holds: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_SHUTDOWN && fault_now |=> state_q == msr_pkg::ST_SHUTDOWN)
    else $error("exit with cause active");
  a_exit_powers: assert property (@(posedge pclk) disable iff (!presetn)
    $past(state_q) == msr_pkg::ST_SHUTDOWN && state_q == msr_pkg::ST_STOPPED
    |-> drive_out.hold_current && drive_out.motor_clk_en && drive_out.pump_en
    && !drive_out.bridge_hiz) else $error("no power on exit");

  // Reference search
  a_ref1_start: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_STOPPED && c_ref && !fault_now
    |=> state_q == msr_pkg::ST_REF1 && tag_q == $past(init1_q)) else $error("no search start");
  a_ref1_rate: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_REF1 |=> step_rate_q == $past({acc_q, vmax_q}))
    else $error("first motion profile");
  a_ref2_rate: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_REF2 |=> step_rate_q == {4'h0, $past(vmin_q)})
    else $error("second motion too fast");
  a_ref_zero: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_REF2 && at_tag && !c_imm && !fault_now
    |=> act_q == `MSR_RESET_POS) else $error("position not cleared");
  a_ref_secure: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_REF2 && at_tag && secure_en && !c_imm && !fault_now
    |=> state_q == msr_pkg::ST_MOVING && tag_q == $past(secure_pos)) else $error("no secure travel");
  a_ref_ignores: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_REF1 && cmd_vld_q && !c_imm && !fault_now && !at_tag
    |=> state_q == msr_pkg::ST_REF1 && $stable(tag_q)) else $error("command in search");
  a_ref2_ignores: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_REF2 && cmd_vld_q && !c_imm && !fault_now && !at_tag
    |=> state_q == msr_pkg::ST_REF2 && $stable(tag_q)) else $error("command in search");
  a_halt_holds: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_IMM_HALT && !c_full && !fault_now
    |=> state_q == msr_pkg::ST_IMM_HALT) else $error("halt left without read");

  // Warnings and switch only report
  a_temp_warn: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_rd |=> prdata[3:2] == $past({sense_in.temp_warn_hi, sense_in.temp_warn_lo}))
    else $error("temperature warning lost");
  a_uv_warn_flag: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_rd |=> prdata[1] == $past(sense_in.undervoltage_warning))
    else $error("supply warning lost");
  a_uv_no_shut: assert property (@(posedge pclk) disable iff (!presetn)
    sense_in.undervoltage_warning && !fault_now && state_q == msr_pkg::ST_STOPPED && !cmd_vld_q
    |=> state_q == msr_pkg::ST_STOPPED) else $error("warning caused shutdown");
  a_switch_flag: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_rd |=> prdata[0] == $past(sense_in.switch_closed))
    else $error("switch flag wrong");
  a_switch_inert: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(sense_in.switch_closed) && state_q == msr_pkg::ST_STOPPED && !cmd_vld_q && !fault_now
    |=> state_q == msr_pkg::ST_STOPPED && $stable(act_q)) else $error("switch acted");

  // Command priority
  a_lost_step_block: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_STOPPED && lost_step_q && cmd_vld_q && !c_ref && !fault_now
    |=> state_q == msr_pkg::ST_STOPPED) else $error("move despite lost step");
  a_lost_moving: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_MOVING && lost_step_q && cmd_vld_q && !c_imm && !c_dec && !fault_now
    |=> $stable(tag_q)) else $error("target moved despite lost step");
  a_imm_priority: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_MOVING && c_imm && !fault_now
    |=> state_q == msr_pkg::ST_IMM_HALT) else $error("halt priority");
  a_dec_priority: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == msr_pkg::ST_MOVING && c_dec && !fault_now
    |=> state_q == msr_pkg::ST_DEC_HALT) else $error("slow halt priority");
endmodule

// *** shared/msr_cfg.svh ***
// Constants for the motor shutdown and reference search controller
`ifndef MSR_CFG_SVH
`define MSR_CFG_SVH
`define MSR_ADDR_CMD 12'h000
`define MSR_ADDR_TARGET 12'h004
`define MSR_ADDR_SECURE 12'h008
`define MSR_ADDR_INIT1 12'h00C
`define MSR_ADDR_INIT2 12'h010
`define MSR_ADDR_VEL 12'h014
`define MSR_ADDR_STATUS 12'h018
`define MSR_ADDR_ACTUAL_POSITION 12'h01C
`define MSR_ADDR_TGTPOS 12'h020
`define MSR_CMD_FULL_STATUS 4'h1
`define MSR_CMD_LOAD_TARGET 4'h2
`define MSR_CMD_GO_SAFE 4'h3
`define MSR_CMD_REF_SEARCH 4'h4
`define MSR_CMD_IMM_HALT 4'h5
`define MSR_CMD_DEC_HALT 4'h6
`define MSR_SECURE_OFF 11'h400
`define MSR_SECURE_SHIFT 5
`define MSR_STEP_DIV 16'h0400
`define MSR_RESET_POS 16'h0000
`endif

// *** shared/msr_pkg.sv ***
// Types for the motor shutdown and reference search controller
package msr_pkg;
  typedef enum logic [6:0] {
    ST_SHUTDOWN = 7'b000_0001,
    ST_STOPPED = 7'b000_0010,
    ST_MOVING = 7'b000_0100,
    ST_REF1 = 7'b000_1000,
    ST_REF2 = 7'b001_0000,
    ST_DEC_HALT = 7'b010_0000,
    ST_IMM_HALT = 7'b100_0000
  } msr_state_e;
  typedef struct packed {
    logic thermal_shutdown;
    logic temp_warn_hi;
    logic temp_warn_lo;
    logic undervoltage_shutdown;
    logic undervoltage_warning;
    logic electrical_defect;
    logic pump_failure;
    logic switch_closed;
  } msr_sense_s;
  typedef struct packed {
    logic bridge_hiz;
    logic hold_current;
    logic motor_clk_en;
    logic pump_en;
  } msr_drive_s;
endpackage

// *** dv/msr_env_model.sv ***
// Far-side model of the sensing front end that feeds the controller flags
`timescale 1ns/100ps
module msr_env_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire msr_pkg::msr_sense_s cond_req,
  output msr_pkg::msr_sense_s sense_out
);
  // Comparator outputs settle into one synchronous flag update, as the design expects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_out <= '0;
    end else begin
      sense_out <= cond_req;
    end
  end
endmodule

// *** dv/motor_shutdown_reference_control_tb.sv ***
// Self-checking bench for the shutdown and reference search controller
`timescale 1ns/100ps
`include "msr_cfg.svh"
module motor_shutdown_reference_control_tb;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, a;
  logic [3:0] pstrb;
  logic pready, pslverr, err, step_q, dir_q;
  logic [7:0] step_rate_q;
  msr_pkg::msr_sense_s cond_req, sense_in;
  msr_pkg::msr_drive_s drive_out;
  int errors, total_checks;
  logic [7:0] w_mask [4] = '{8'h01, 8'h08, 8'h20, 8'h40};
  logic [7:0] w_stat [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
  logic [7:0] s_mask [4] = '{8'h80, 8'h10, 8'h04, 8'h02};
  logic [7:0] s_stat [4] = '{8'h10, 8'h00, 8'h20, 8'h40};

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Short step interval keeps motions and reference runs brief
  msr_ctrl #(.POS_W(16), .STEP_DIV(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_in(sense_in),
    .drive_out(drive_out), .step_q(step_q), .dir_q(dir_q), .step_rate_q(step_rate_q));
  msr_env_model env_u (.pclk(pclk), .presetn(presetn), .cond_req(cond_req),
    .sense_out(sense_in));

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_drv(input msr_pkg::msr_drive_s got, input msr_pkg::msr_drive_s exp);
    chk({28'h000_0000, got}, {28'h000_0000, exp});
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk({31'h0000_0000, pready}, 32'h0000_0001);
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [3:0] c);
    xfer(1'b1, `MSR_ADDR_CMD, {28'h000_0000, c});
  endtask

  // Polls a register field; a bound that runs out is reported as a mismatch
  task automatic wait_reg(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      xfer(1'b0, ad, 32'h0000_0000);
      n++;
    end while ((rd & m) !== e && n < 2000);
    chk(rd & m, e);
    if ((rd & m) !== e) begin
      end_of_test();
    end
  endtask

  task automatic wait_st(input msr_pkg::msr_state_e s);
    wait_reg(`MSR_ADDR_STATUS, 32'h0000_7F00, {17'h0_0000, s, 8'h00});
  endtask

  task automatic rd_st;
    xfer(1'b0, `MSR_ADDR_STATUS, 32'h0000_0000);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    cond_req = '0;
    presetn = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_drv(drive_out, 4'h8);
    wait_st(msr_pkg::ST_SHUTDOWN);
    cmd(`MSR_CMD_FULL_STATUS);
    wait_st(msr_pkg::ST_STOPPED);
    chk_drv(drive_out, 4'h7);
    // Switch and warning flags mirror into status and leave the state alone
    for (int i = 0; i < 4; i++) begin
      cond_req <= w_mask[i];
      rd_st();
      rd_st();
      chk({24'h00_0000, rd[7:0]}, {24'h00_0000, w_stat[i]});
      chk({25'h000_0000, rd[14:8]}, {25'h000_0000, msr_pkg::ST_STOPPED});
    end
    cond_req <= '0;
    // Each cause interrupts a motion and needs clearing plus a status read
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `MSR_ADDR_TARGET, 32'h0000_0100 * (i + 1));
      cmd(`MSR_CMD_LOAD_TARGET);
      wait_st(msr_pkg::ST_MOVING);
      cond_req <= s_mask[i];
      wait_st(msr_pkg::ST_SHUTDOWN);
      chk_drv(drive_out, 4'h8);
      chk({25'h000_0000, rd[6:0]}, {25'h000_0000, s_stat[i][6:0]});
      xfer(1'b0, `MSR_ADDR_ACTUAL_POSITION, 32'h0000_0000);
      a = rd;
      xfer(1'b0, `MSR_ADDR_TGTPOS, 32'h0000_0000);
      chk(rd, a);
      cmd(`MSR_CMD_FULL_STATUS);
      rd_st();
      chk({25'h000_0000, rd[14:8]}, {25'h000_0000, msr_pkg::ST_SHUTDOWN});
      cond_req <= '0;
      rd_st();
      cmd(`MSR_CMD_FULL_STATUS);
      wait_st(msr_pkg::ST_STOPPED);
    end
    xfer(1'b1, `MSR_ADDR_TARGET, 32'h0000_0800);
    cmd(`MSR_CMD_LOAD_TARGET);
    wait_st(msr_pkg::ST_MOVING);
    cmd(`MSR_CMD_DEC_HALT);
    wait_st(msr_pkg::ST_STOPPED);
    xfer(1'b0, 12'h100, 32'h0000_0000);
    chk({err, rd[30:0]}, 32'h8000_0000);
    // Reference runs: secure travel disabled, then enabled, then disabled with the run cut short by an immediate halt
    xfer(1'b1, `MSR_ADDR_VEL, 32'h0000_0321);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, `MSR_ADDR_ACTUAL_POSITION, 32'h0000_0000);
      a = rd;
      xfer(1'b1, `MSR_ADDR_INIT1, {16'h0000, a[15:0] + 16'h0200});
      xfer(1'b1, `MSR_ADDR_INIT2, {16'h0000, a[15:0] + 16'h0100});
      xfer(1'b1, `MSR_ADDR_SECURE, (i == 1) ? 32'h0000_0001 : 32'h0000_0400);
      cmd(`MSR_CMD_REF_SEARCH);
      cmd(`MSR_CMD_LOAD_TARGET);
      cmd(`MSR_CMD_DEC_HALT);
      rd_st();
      chk({31'h0000_0000, rd[11] | rd[12]}, 32'h0000_0001);
      chk({22'h00_0000, step_q, dir_q, step_rate_q}, {22'h00_0000, 2'b11, 8'h32});
      if (i == 2) begin
        cmd(`MSR_CMD_IMM_HALT);
        wait_st(msr_pkg::ST_IMM_HALT);
        chk({31'h0000_0000, rd[7]}, 32'h0000_0001);
        cmd(`MSR_CMD_LOAD_TARGET);
        rd_st();
        chk({25'h000_0000, rd[14:8]}, {25'h000_0000, msr_pkg::ST_IMM_HALT});
        cmd(`MSR_CMD_FULL_STATUS);
      end else begin
        wait_st(msr_pkg::ST_STOPPED);
        xfer(1'b0, `MSR_ADDR_ACTUAL_POSITION, 32'h0000_0000);
        chk(rd & 32'h0000_FFFF, (i == 1) ? 32'h0000_0020 : 32'h0000_0000);
      end
      wait_st(msr_pkg::ST_STOPPED);
    end
    // Lost step is still set after the halt, so a new target must be refused
    cmd(`MSR_CMD_LOAD_TARGET);
    rd_st();
    chk({24'h00_0000, rd[14:7]}, {24'h00_0000, msr_pkg::ST_STOPPED, 1'b1});
    end_of_test();
  end
endmodule
